// [rrs_pkg.sv]
// Constants and types for the rotate and fill-ones execution datapath
// How it works
// - The rotate operation moves the byte right one place, bit 0 wraps into bit 7, carry untouched.
// - The rotate result goes to the working register when the destination bit is 0, else back to the file register.
// - An access bit of 0 addresses the fast access bank, a 1 forms the address from the bank select value.
// - The fill operation writes FFh into the addressed file register whatever it held.
package rrs_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_INSTR   = 8'h00;
	localparam logic [7:0] OFS_WREG    = 8'h04;
	localparam logic [7:0] OFS_BANKSEL = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0C;

	// Status bit positions
	localparam int ST_BUSY    = 0;
	localparam int ST_ZERO    = 1;
	localparam int ST_NEG     = 2;
	localparam int ST_ILLEGAL = 3;
	localparam int ST_REFUSED = 4;

	// Instruction word fields
	localparam int IW_DEST = 9;
	localparam int IW_BANK = 8;

	// Opcode patterns
	localparam logic [5:0] OPC_ROT = 6'h10;
	localparam logic [6:0] OPC_SET = 7'h34;

	// Values after reset and data constants
	localparam logic [15:0] RST_INSTR   = 16'h0000;
	localparam logic [7:0]  RST_WREG    = 8'h00;
	localparam logic [3:0]  RST_BANKSEL = 4'h0;
	localparam logic [7:0]  FILL_VALUE  = 8'hFF;
	localparam logic [11:0] RST_ADDR    = 12'h000;

	// Fast access bank split: low half to bank 0, high half to last bank
	localparam logic [3:0] ACC_LOW_BANK  = 4'h0;
	localparam logic [3:0] ACC_HIGH_BANK = 4'hF;

	// Instruction phases, one-hot
	typedef enum logic [4:0] {
		PH_IDLE = 5'h01,
		PH_Q1   = 5'h02,
		PH_Q2   = 5'h04,
		PH_Q3   = 5'h08,
		PH_Q4   = 5'h10
	} rrs_phase_type;

	// Opcode decode, used by the issue logic and the datapath
	function automatic logic is_rot(input logic [15:0] iw);
		is_rot = (iw[15:10] == OPC_ROT);
	endfunction : is_rot

	function automatic logic is_set(input logic [15:0] iw);
		is_set = (iw[15:9] == OPC_SET);
	endfunction : is_set

	// Right rotate without carry
	function automatic logic [7:0] rot_right(input logic [7:0] v);
		rot_right = {v[0], v[7:1]};
	endfunction : rot_right

endpackage : rrs_pkg

// [rrs_core.sv]
// Execution datapath for the rotate-right and fill-ones file operations
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module rrs_core (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic      [11:0] o_mem_addr,
	output logic             o_mem_re,
	output logic             o_mem_we,
	output logic      [7:0]  o_mem_wdata,
	input  wire logic [7:0]  i_mem_rdata,
	output logic             o_busy
);

	rrs_pkg::rrs_phase_type ph_r;
	rrs_pkg::rrs_phase_type ph_nxt;
	logic [15:0] instr_r;
	logic [7:0]  wreg_r;
	logic [3:0]  bsel_r;
	logic        zero_r;
	logic        neg_r;
	logic        illegal_r;
	logic        refused_r;
	logic [31:0] rdata_r;
	logic [11:0] mem_addr_r;
	logic        mem_re_r;
	logic        mem_we_r;
	logic [7:0]  mem_wdata_r;
	logic        busy_r;

	// Bus decode
	wire        wr_instr  = i_wr && (i_addr == rrs_pkg::OFS_INSTR);
	wire        wr_wreg   = i_wr && (i_addr == rrs_pkg::OFS_WREG);
	wire        wr_bsel   = i_wr && (i_addr == rrs_pkg::OFS_BANKSEL);
	wire        wr_stat   = i_wr && (i_addr == rrs_pkg::OFS_STATUS);
	wire        idle      = (ph_r == rrs_pkg::PH_IDLE);
	wire [15:0] new_iw    = i_wdata[15:0];
	wire        new_legal = rrs_pkg::is_rot(new_iw) || rrs_pkg::is_set(new_iw);
	wire        start     = wr_instr && idle && new_legal;
	wire        bad_issue = wr_instr && idle && !new_legal;
	wire        busy_hit  = wr_instr && !idle;

	// Operand address and result
	wire        op_rot   = rrs_pkg::is_rot(instr_r);
	wire        to_file  = !op_rot || instr_r[rrs_pkg::IW_DEST];
	wire [3:0]  acc_bank = instr_r[7] ? rrs_pkg::ACC_HIGH_BANK
	                                  : rrs_pkg::ACC_LOW_BANK;
	wire [3:0]  eff_bank = instr_r[rrs_pkg::IW_BANK] ? bsel_r
	                                                 : acc_bank;
	wire [11:0] eff_addr = {eff_bank, instr_r[7:0]};
	wire [7:0]  result   = op_rot ? rrs_pkg::rot_right(i_mem_rdata)
	                              : rrs_pkg::FILL_VALUE;
	wire        commit   = (ph_r == rrs_pkg::PH_Q3);

	// Read mux
	wire [31:0] stat_word = {27'h0000000, refused_r, illegal_r, neg_r,
	                         zero_r, !idle};
	wire [31:0] rd_mux =
		(i_addr == rrs_pkg::OFS_INSTR)   ? {16'h0000, instr_r} :
		(i_addr == rrs_pkg::OFS_WREG)    ? {24'h000000, wreg_r} :
		(i_addr == rrs_pkg::OFS_BANKSEL) ? {28'h0000000, bsel_r} :
		(i_addr == rrs_pkg::OFS_STATUS)  ? stat_word : 32'h00000000;

	// Phase sequencer: one instruction takes Q1..Q4
	always_comb begin
		case (ph_r)
			rrs_pkg::PH_IDLE: ph_nxt = start ? rrs_pkg::PH_Q1 : rrs_pkg::PH_IDLE;
			rrs_pkg::PH_Q1:   ph_nxt = rrs_pkg::PH_Q2;
			rrs_pkg::PH_Q2:   ph_nxt = rrs_pkg::PH_Q3;
			rrs_pkg::PH_Q3:   ph_nxt = rrs_pkg::PH_Q4;
			rrs_pkg::PH_Q4:   ph_nxt = rrs_pkg::PH_IDLE;
			default:          ph_nxt = rrs_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ph_r    <= rrs_pkg::PH_IDLE;
			instr_r <= rrs_pkg::RST_INSTR;
			busy_r  <= 1'b0;
		end else begin
			ph_r   <= ph_nxt;
			busy_r <= (ph_nxt != rrs_pkg::PH_IDLE); // Busy straight from a flop
			if (start) begin
				instr_r <= new_iw;
			end
		end
	end

	// Data memory port: read in Q2, write in Q4
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mem_addr_r  <= rrs_pkg::RST_ADDR;
			mem_re_r    <= 1'b0;
			mem_we_r    <= 1'b0;
			mem_wdata_r <= 8'h00;
		end else begin
			mem_re_r <= (ph_r == rrs_pkg::PH_Q1);
			mem_we_r <= commit && to_file;
			if (ph_r == rrs_pkg::PH_Q1) begin
				mem_addr_r <= eff_addr;
			end
			if (commit && to_file) begin
				mem_wdata_r <= result;
			end
		end
	end

	// Working register, bank select and flags
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wreg_r <= rrs_pkg::RST_WREG;
			bsel_r <= rrs_pkg::RST_BANKSEL;
			zero_r <= 1'b0;
			neg_r  <= 1'b0;
		end else if (commit) begin
			if (!to_file) begin
				wreg_r <= result;
			end
			if (op_rot) begin
				zero_r <= (result == 8'h00);
				neg_r  <= result[7];
			end
		end else if (idle) begin
			if (wr_wreg) begin
				wreg_r <= i_wdata[7:0];
			end
			if (wr_bsel) begin
				bsel_r <= i_wdata[3:0];
			end
			if (wr_stat) begin
				zero_r <= i_wdata[rrs_pkg::ST_ZERO];
				neg_r  <= i_wdata[rrs_pkg::ST_NEG];
			end
		end
	end

	// Sticky error flags, write one to clear, set wins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			illegal_r <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			illegal_r <= bad_issue ||
				(illegal_r && !(wr_stat && i_wdata[rrs_pkg::ST_ILLEGAL]));
			refused_r <= busy_hit ||
				(refused_r && !(wr_stat && i_wdata[rrs_pkg::ST_REFUSED]));
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= i_rd ? rd_mux : 32'h00000000;
		end
	end

	assign o_rdata     = rdata_r;
	assign o_mem_addr  = mem_addr_r;
	assign o_mem_re    = mem_re_r;
	assign o_mem_we    = mem_we_r;
	assign o_mem_wdata = mem_wdata_r;
	assign o_busy      = busy_r;

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	wire q3_rot = commit && op_rot;

	property p_rot_value;
		q3_rot && instr_r[rrs_pkg::IW_DEST] |=> o_mem_we &&
			o_mem_wdata == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])};
	endproperty
	a_rot_value: assert property (p_rot_value)
		else $error("rotate result wrong");

	property p_rot_to_w;
		q3_rot && !instr_r[rrs_pkg::IW_DEST] |=> !o_mem_we &&
			wreg_r == {$past(i_mem_rdata[0]), $past(i_mem_rdata[7:1])};
	endproperty
	a_rot_to_w: assert property (p_rot_to_w)
		else $error("rotate to working register wrong");

	property p_access_bank;
		(ph_r == rrs_pkg::PH_Q2) && !instr_r[rrs_pkg::IW_BANK] |->
			o_mem_re && o_mem_addr[11:8] == (instr_r[7] ? 4'hF : 4'h0);
	endproperty
	a_access_bank: assert property (p_access_bank)
		else $error("access bank address wrong");

	property p_bsel_bank;
		(ph_r == rrs_pkg::PH_Q2) && instr_r[rrs_pkg::IW_BANK] |->
			o_mem_addr == {bsel_r, instr_r[7:0]};
	endproperty
	a_bsel_bank: assert property (p_bsel_bank)
		else $error("banked address wrong");

	property p_fill;
		commit && !op_rot |=> o_mem_we && o_mem_wdata == 8'hFF &&
			$stable(zero_r) && $stable(neg_r) && $stable(wreg_r);
	endproperty
	a_fill: assert property (p_fill)
		else $error("fill ones wrong");

	property p_flags;
		q3_rot |=> zero_r == ($past(i_mem_rdata) == 8'h00);
	endproperty
	a_flags: assert property (p_flags)
		else $error("zero flag wrong");

	property p_neg;
		q3_rot |=> neg_r == $past(i_mem_rdata[0]);
	endproperty
	a_neg: assert property (p_neg)
		else $error("negative flag wrong");

	property p_timing;
		start |=> (ph_r == rrs_pkg::PH_Q1) ##1 o_mem_re ##1 !o_mem_re
			##1 (o_mem_we == to_file) ##1 idle && !o_mem_we;
	endproperty
	a_timing: assert property (p_timing)
		else $error("instruction not four phases");

	c_rot_file: cover property (q3_rot && instr_r[rrs_pkg::IW_DEST]);
	c_rot_w: cover property (q3_rot && !instr_r[rrs_pkg::IW_DEST]);
	c_fill_acc: cover property (commit && !op_rot
		&& !instr_r[rrs_pkg::IW_BANK]);
	c_refused: cover property (busy_hit);
	c_illegal: cover property (bad_issue);

endmodule : rrs_core

// [tb.sv]
// Testbench for the rotate-right and fill-ones execution datapath
`timescale 1ns/10ps
module tb;
	logic        i_clk;
	logic        i_rst;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata;
	logic        i_wr;
	logic        i_rd;
	logic [31:0] o_rdata;
	logic [11:0] o_mem_addr;
	logic        o_mem_re;
	logic        o_mem_we;
	logic [7:0]  o_mem_wdata;
	logic [7:0]  i_mem_rdata;
	logic        o_busy;
	logic [7:0]  mem [0:4095];
	int          failures;
	int          tests_run;

	rrs_core rrs_core_inst (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_mem_addr(o_mem_addr), .o_mem_re(o_mem_re), .o_mem_we(o_mem_we),
		.o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata),
		.o_busy(o_busy));

	// Clock, 20 ns period
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	// Data memory: answers one cycle after the read, toggles when idle
	always @(posedge i_clk) begin
		if (o_mem_we === 1'b1)
			mem[o_mem_addr] <= o_mem_wdata;
		i_mem_rdata <= (o_mem_re === 1'b1) ? mem[o_mem_addr] : ~i_mem_rdata;
	end

	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd   <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rd

	// Issue an instruction and count the busy cycles
	task automatic exec(input logic [15:0] iw);
		int n;
		n = 0;
		wr(8'h00, {16'h0000, iw});
		for (int k = 0; k < 10; k++) begin
			#1;
			if (o_busy !== 1'b1)
				break;
			n++;
			@(posedge i_clk);
		end
		chk(n, 4);
	endtask : exec

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	// Watchdog against a hang
	initial begin
		#(2000 * 20);
		failures++;
		print_verdict();
	end

	// Main sequence
	initial begin
		failures = 0;
		tests_run = 0;
		i_rst = 1'b1;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_mem_rdata = 8'h00;
		for (int k = 0; k < 4096; k++)
			mem[k] = 8'h5A;
		mem[12'h323] = 8'hD7;
		mem[12'hF90] = 8'h01;
		mem[12'h044] = 8'h00;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		wr(8'h08, 32'h3);
		wr(8'h04, 32'h11);
		// Rotate back to file, banked, negative result
		exec(16'h4323);
		chk(mem[12'h323], 8'hEB);
		rd(8'h04, 32'h11);
		rd(8'h0C, 32'h04);
		$display("Test rotate to file done");
		// Rotate to W through the high access half
		exec(16'h4090);
		rd(8'h04, 32'h80);
		chk(mem[12'hF90], 8'h01);
		// Rotate of zero from the low access half
		exec(16'h4044);
		rd(8'h04, 32'h00);
		rd(8'h0C, 32'h02);
		$display("Test rotate to W done");
		// Fill, banked then access bank; flags stay put
		exec(16'h6910);
		chk(mem[12'h310], 8'hFF);
		exec(16'h68F0);
		chk(mem[12'hFF0], 8'hFF);
		exec(16'h6823);
		chk(mem[12'h023], 8'hFF);
		chk(mem[12'h323], 8'hEB);
		rd(8'h0C, 32'h02);
		rd(8'h04, 32'h00);
		$display("Test fill done");
		// Illegal opcode sets its sticky bit, a one clears it
		wr(8'h00, 32'h0000FFFF);
		rd(8'h0C, 32'h0000000A);
		wr(8'h0C, 32'h0000000A);
		rd(8'h0C, 32'h00000002);
		// Issue while busy refused, W write while busy ignored
		wr(8'h00, 32'h00006944);
		wr(8'h00, 32'h00004323);
		wr(8'h04, 32'h00000077);
		rd(8'h0C, 32'h00000012);
		rd(8'h00, 32'h00006944);
		rd(8'h04, 32'h00000000);
		chk(mem[12'h344], 8'hFF);
		chk(mem[12'h323], 8'hEB);
		wr(8'h0C, 32'h00000012);
		rd(8'h08, 32'h00000003);
		// Read data stands one cycle only
		@(posedge i_clk);
		#1;
		chk(o_rdata, 32'h00000000);
		rd(8'h0C, 32'h00000002);
		rd(8'h10, 32'h00000000);
		$display("Test refusals done");
		// Reset in mid-run cuts the instruction, no write follows
		wr(8'h00, 32'h00004323);
		@(posedge i_clk);
		i_rst <= 1'b1;
		@(posedge i_clk);
		#1;
		chk(o_busy, 1'b0);
		chk(o_mem_re, 1'b0);
		chk(o_mem_we, 1'b0);
		@(posedge i_clk);
		i_rst <= 1'b0;
		rd(8'h04, 32'h00000000);
		rd(8'h08, 32'h00000000);
		rd(8'h0C, 32'h00000000);
		chk(mem[12'h323], 8'hEB);
		exec(16'h6955);
		chk(mem[12'h055], 8'hFF);
		$display("Test reset done");
		print_verdict();
	end
endmodule : tb
